// ---- sar_pkg.sv ----
package sar_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ           = 100;
   localparam int CLK_PERIOD_NS     = 10;
   localparam int STATUS_DELAY_NS   = 40;
   localparam int STATUS_DELAY_CYC  =
      (STATUS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INT_CLK_KHZ       = 575;
   localparam int OSC_HALF_CYC      = (CLK_MHZ * 1000) / (2 * INT_CLK_KHZ);
   localparam int SHORT_SETTLE_CYC  = 3;

   // ---------------------------------------------------------------
   // Conversion geometry
   // ---------------------------------------------------------------
   localparam int          RES_BITS   = 12;
   localparam logic [3:0]  FIRST_STEP = 4'h1;
   localparam logic [3:0]  LAST_STEP  = 4'hc;
   localparam logic [3:0]  MSB_IDX    = 4'hb;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam int          ADDR_W        = 8;
   localparam logic [7:0]  OFF_CTRL      = 8'h00;
   localparam logic [7:0]  OFF_IRQ_STAT  = 8'h04;
   localparam logic [7:0]  OFF_IRQ_MASK  = 8'h08;
   localparam logic [7:0]  OFF_RESULT    = 8'h0c;
   localparam logic [7:0]  OFF_EDGES     = 8'h10;
   localparam int          CTRL_EXT_SEL  = 0;
   localparam int          IRQ_DONE      = 0;
   localparam int          IRQ_START     = 1;
   localparam int          IRQ_W         = 2;
   localparam int          RES_BUSY_BIT  = 16;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic convert_start;
      logic ext_clk;
      logic clock_inhibit;
      logic short_cycle;
      logic comp_keep;
   } sar_pins_t;

   typedef struct packed {
      logic [RES_BITS-1:0] result_n;
      logic                msb_n;
      logic [RES_BITS-1:0] dac_code;
      logic                busy;
      logic                clock_out;
   } sar_outs_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_ARMED = 3'h1,
      ST_RUN   = 3'h2,
      ST_CHECK = 3'h3,
      ST_DELAY = 3'h4
   } sar_state_t;

   typedef struct packed {
      sar_pins_t           s1;
      sar_pins_t           s2;
      logic                start_prev;
      logic [7:0]          osc_cnt;
      logic                osc_lvl;
      logic                clk_out;
      sar_state_t          state;
      logic [3:0]          step;
      logic [RES_BITS-1:0] sar;
      logic                busy;
      logic [2:0]          dly;
      logic [1:0]          chk;
      logic                ext_sel;
      logic [IRQ_W-1:0]    irq_stat;
      logic [IRQ_W-1:0]    irq_mask;
      logic [3:0]          falls;
      logic [31:0]         rdata;
   } sar_regs_t;

endpackage

// ---- sar_conversion_sequencer.sv ----
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// R1: 12-bit successive approximation, MSB first
// R2: Register drives result pins and DAC together
// R3: Comparator at step end keeps or rejects
// R4: Start command sets busy
// R5: Busy releases gated clock, 13 cycles
// R6: Init on start lead, release on trail
// R7: MSB trial first, then decide n, trial n+1
// R8: Busy clears 40 ns after last decision; the code takes 70 ns when short-cycled
// R9: Busy clear forces clock output low
// R10: Result pins change on clock rising edge
// R11: Host captures on busy falling edge
// R12: Result pins are negative-true
// R13: Unipolar coding is complemented straight binary
// R14: MSB also given inverted for bipolar
// R15: Thirteen falling edges per full conversion
// R16: Early termination input ends conversion
// R17: Terminate when next trial bit shows low
// R18: Host start pulse at least 100 ns
// R19: External or internal clock, inhibit stops it
module sar_conversion_sequencer (
   input  wire logic                          clk,
   input  wire logic                          rstn,
   input  wire sar_pkg::sar_pins_t            pins,
   output sar_pkg::sar_outs_t                 outs,
   output logic                               irq,
   input  wire logic [sar_pkg::ADDR_W-1:0]    addr,
   input  wire logic [31:0]                   wr_data,
   input  wire logic                          wr_en,
   input  wire logic                          rd_en,
   output logic [31:0]                        rd_data
);

   sar_pkg::sar_regs_t q;
   sar_pkg::sar_regs_t d;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic                       start_rise;
      logic                       start_fall;
      logic                       src_lvl;
      logic                       clk_rise;
      logic [3:0]                 idx;
      logic [sar_pkg::IRQ_W-1:0]  ev;
      logic [sar_pkg::IRQ_W-1:0]  clr;
      d          = q;
      start_rise = 1'b0;
      start_fall = 1'b0;
      src_lvl    = 1'b0;
      clk_rise   = 1'b0;
      idx        = 4'h0;
      ev         = '0;
      clr        = '0;
      d.rdata    = '0;

      // Pins are asynchronous to clk; only s2 feeds logic
      d.s1         = pins;
      d.s2         = q.s1;
      d.start_prev = q.s2.convert_start;
      start_rise   = q.s2.convert_start & ~q.start_prev;
      start_fall   = ~q.s2.convert_start & q.start_prev;

      // Free-running internal oscillator
      if (q.osc_cnt == 8'(sar_pkg::OSC_HALF_CYC - 1)) begin
         d.osc_cnt = '0;
         d.osc_lvl = ~q.osc_lvl;
      end else begin
         d.osc_cnt = q.osc_cnt + 8'h01;
      end

      // Gated conversion clock
      src_lvl   = q.ext_sel ? q.s2.ext_clk : q.osc_lvl; // R19
      d.clk_out = src_lvl & ~q.s2.clock_inhibit // R19
                & (q.state == sar_pkg::ST_RUN
                   || q.state == sar_pkg::ST_CHECK
                   || q.state == sar_pkg::ST_DELAY); // R5 R9
      clk_rise  = d.clk_out & ~q.clk_out;

      case (q.state)
         sar_pkg::ST_ARMED: begin
            if (start_fall) begin
               // Restart the oscillator so the first step is a full period
               d.osc_cnt = '0;
               d.osc_lvl = 1'b0;
               d.state   = sar_pkg::ST_RUN; // R6
            end
         end
         sar_pkg::ST_RUN: begin
            if (clk_rise) begin // R10
               if (q.step == '0) begin
                  d.sar[sar_pkg::MSB_IDX] = 1'b1; // R7
                  d.step = sar_pkg::FIRST_STEP;
               end else begin
                  idx = 4'(sar_pkg::RES_BITS) - q.step;
                  d.sar[idx] = q.s2.comp_keep; // R1 R3
                  if (q.step == sar_pkg::LAST_STEP) begin
                     d.state = sar_pkg::ST_DELAY;
                     d.dly   = '0;
                  end else begin
                     d.sar[idx - 4'h1] = 1'b1; // R7
                     d.step  = q.step + 4'h1;
                     d.state = sar_pkg::ST_CHECK;
                     d.chk   = '0;
                  end
               end
            end
         end
         sar_pkg::ST_CHECK: begin
            // Wait for the new trial bit to come back through the
            // short-cycle pin synchroniser before judging it
            if (q.chk == 2'(sar_pkg::SHORT_SETTLE_CYC - 1)) begin
               if (!q.s2.short_cycle) begin
                  d.state = sar_pkg::ST_DELAY; // R16 R17
                  d.dly   = '0;
               end else begin
                  d.state = sar_pkg::ST_RUN;
               end
            end else begin
               d.chk = q.chk + 2'h1;
            end
         end
         sar_pkg::ST_DELAY: begin
            if (q.dly == 3'(sar_pkg::STATUS_DELAY_CYC - 1)) begin
               d.busy  = 1'b0; // R8 R11
               d.state = sar_pkg::ST_IDLE; // R9
               ev[sar_pkg::IRQ_DONE] = 1'b1;
            end else begin
               d.dly = q.dly + 3'h1;
            end
         end
         default: begin
            d.state = sar_pkg::ST_IDLE;
         end
      endcase

      // Status drop forces the clock low in the same edge; gating on the
      // old state alone would leave one high cycle with busy already low
      if (!d.busy) begin
         d.clk_out = 1'b0; // R9
      end
      // Counted after the forced low so the closing fall is included
      if (!d.clk_out && q.clk_out && q.busy) begin
         d.falls = q.falls + 4'h1; // R15
      end

      // A leading edge always restarts, even mid-conversion
      if (start_rise) begin
         d.sar   = '0; // R6
         d.busy  = 1'b1; // R4
         d.step  = '0;
         d.falls = '0;
         d.state = sar_pkg::ST_ARMED;
         ev[sar_pkg::IRQ_START] = 1'b1;
      end

      // -------------------------------------------------------------
      // Register port
      // -------------------------------------------------------------
      if (wr_en) begin
         case (addr)
            sar_pkg::OFF_CTRL: begin
               d.ext_sel = wr_data[sar_pkg::CTRL_EXT_SEL];
            end
            sar_pkg::OFF_IRQ_STAT: begin
               clr = wr_data[sar_pkg::IRQ_W-1:0];
            end
            sar_pkg::OFF_IRQ_MASK: begin
               d.irq_mask = wr_data[sar_pkg::IRQ_W-1:0];
            end
            default: begin
            end
         endcase
      end
      // Set wins over a clear in the same cycle
      d.irq_stat = (q.irq_stat & ~clr) | ev;

      if (rd_en) begin
         case (addr)
            sar_pkg::OFF_CTRL: begin
               d.rdata[sar_pkg::CTRL_EXT_SEL] = q.ext_sel;
            end
            sar_pkg::OFF_IRQ_STAT: begin
               d.rdata[sar_pkg::IRQ_W-1:0] = q.irq_stat;
            end
            sar_pkg::OFF_IRQ_MASK: begin
               d.rdata[sar_pkg::IRQ_W-1:0] = q.irq_mask;
            end
            sar_pkg::OFF_RESULT: begin
               d.rdata[sar_pkg::RES_BITS-1:0] = q.sar;
               d.rdata[sar_pkg::RES_BUSY_BIT] = q.busy;
            end
            sar_pkg::OFF_EDGES: begin
               d.rdata[3:0] = q.falls;
            end
            default: begin
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q       <= '0;
         q.state <= sar_pkg::ST_IDLE;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   always_comb begin
      outs.result_n  = ~q.sar; // R2 R12 R13
      outs.msb_n     = q.sar[sar_pkg::MSB_IDX]; // R14
      outs.dac_code  = q.sar; // R2
      outs.busy      = q.busy;
      outs.clock_out = q.clk_out;
      irq            = |(q.irq_stat & q.irq_mask);
      rd_data        = q.rdata;
   end

endmodule // sar_conversion_sequencer

// ---- sar_seq_sva.sv ----
`timescale 1ns/1ps
module sar_seq_sva (
   input wire logic               clk,
   input wire logic               rstn,
   input wire sar_pkg::sar_pins_t pins,
   input wire sar_pkg::sar_outs_t outs,
   input wire logic               irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // ----------------------------------------------
   // Output relations
   // ----------------------------------------------
   property p_neg; outs.result_n == ~outs.dac_code; endproperty
   a_neg: assert property (p_neg)
      else $error("result pins not inverse of dac code");
   property p_msb; outs.msb_n == ~outs.result_n[11]; endproperty
   a_msb: assert property (p_msb)
      else $error("inverted msb wrong");
   property p_edge;
      $changed(outs.dac_code) |-> $rose(outs.clock_out) || $rose(outs.busy);
   endproperty
   a_edge: assert property (p_edge)
      else $error("result moved off a clock rise");
   property p_idle; !outs.busy |-> !outs.clock_out; endproperty
   a_idle: assert property (p_idle)
      else $error("clock runs while idle");
   // Full resolution: status drops four cycles after the last rise
   property p_done;
      $fell(outs.busy) && pins.short_cycle
         |-> $past(outs.clock_out, 4) && !$past(outs.clock_out, 5);
   endproperty
   a_done: assert property (p_done)
      else $error("status fall not 40 ns after last decision");
   property p_start;
      $rose(pins.convert_start) |-> ##[3:4] outs.busy;
   endproperty
   a_start: assert property (p_start)
      else $error("start did not set busy");
   property p_init;
      $rose(outs.busy) |-> outs.dac_code == 12'h000 && !outs.clock_out;
   endproperty
   a_init: assert property (p_init)
      else $error("register not cleared at start");
   property p_hold;
      pins.convert_start [*4] |=> !$rose(outs.clock_out);
   endproperty
   a_hold: assert property (p_hold)
      else $error("clock ran before start fell");
   property p_run; $rose(outs.busy) |-> ##[1:300] $rose(outs.clock_out);
   endproperty
   a_run: assert property (p_run)
      else $error("gated clock not released");
   c_done: cover property ($fell(outs.busy));
   c_irq: cover property ($rose(irq));
   c_short: cover property ($fell(outs.busy) && !pins.short_cycle);
endmodule // sar_seq_sva

// ---- sar_host_model.sv ----
`timescale 1ns/1ps
module sar_host_model (
   input  wire logic [11:0]        target,
   input  wire sar_pkg::sar_outs_t outs,
   output logic                    keep,
   output logic [11:0]             captured
);
   // Ideal comparator: a trial code at or below the input is kept
   assign keep = (outs.dac_code <= target);
   // Data is settled before the status fall, so latch on it
   always @(negedge outs.busy) captured = ~outs.result_n;
endmodule // sar_host_model

// ---- sar_conversion_sequencer_test.sv ----
`timescale 1ns/1ps
module sar_conversion_sequencer_test;
   logic               clk, rstn, st, xc, inh, sc_mode, keep, irq;
   logic               wr_en, rd_en;
   logic [7:0]         addr;
   logic [31:0]        wr_data, rd_data, rv;
   logic [11:0]        target, captured;
   logic               co;
   int                 err_count, tests_run;
   sar_pkg::sar_pins_t pins;
   sar_pkg::sar_outs_t outs;
   logic [11:0]        tv [4] = '{12'h676, 12'h000, 12'hfff, 12'h800};
   // Short cycle wired to the bit after the last wanted one
   assign pins = {st, xc, inh, sc_mode ? outs.result_n[1] : 1'b1, keep};
   sar_conversion_sequencer dut (.clk(clk), .rstn(rstn), .pins(pins),
      .outs(outs), .irq(irq), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));
   sar_host_model host (.target(target), .outs(outs), .keep(keep),
      .captured(captured));
   // ----------------------------------------------
   // Tasks
   // ----------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask
   task automatic conv(input logic [11:0] t);
      target <= t;
      @(posedge clk);
      st <= 1'b1;
      repeat (10) @(posedge clk);
      st <= 1'b0;
      repeat (6000) begin
         if (outs.busy === 1'b1) begin
            @(posedge clk);
            #1;
         end
      end
      repeat (2) @(posedge clk);
      #1 chk(outs.busy, 32'h0);
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // External clock source, 16 system cycles a period
   initial forever begin
      repeat (8) @(posedge clk);
      xc <= ~xc;
   end
   initial begin
      repeat (30000) @(posedge clk);
      err_count++;
      stop_test();
   end
   initial begin
      {rstn, st, xc, inh, sc_mode, wr_en, rd_en} = '0;
      addr = 8'h00;
      wr_data = 32'h0;
      target = 12'h000;
      err_count = 0;
      tests_run = 0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      #1 chk(outs.result_n, 32'hfff);
      wr(8'h08, 32'h0);
      foreach (tv[i]) begin
         conv(tv[i]);
         chk(captured, tv[i]);
         chk(outs.result_n ^ tv[i], 32'hfff);
         chk(outs.msb_n, tv[i][11]);
         rd(8'h0c, rv);
         chk(rv, tv[i]);
         rd(8'h10, rv);
         chk(rv, 32'hd);
         chk(irq, i > 0);
         rd(8'h04, rv);
         chk(rv, 32'h3);
         wr(8'h04, 32'h3);
         wr(8'h08, 32'h3);
         @(posedge clk);
         #1 chk(irq, 32'h0);
      end
      rd(8'h20, rv);
      chk(rv, 32'h0);
      wr(8'h00, 32'h1);
      rd(8'h00, rv);
      chk(rv, 32'h1);
      fork
         conv(12'h5a3);
         begin
            repeat (60) @(posedge clk);
            inh <= 1'b1;
            repeat (4) @(posedge clk);
            #1 co = outs.clock_out;
            repeat (100) @(posedge clk);
            #1 chk(outs.clock_out, co);
            chk(co, 32'h0);
            chk(outs.busy, 32'h1);
            @(posedge clk);
            inh <= 1'b0;
         end
      join
      chk(captured, 12'h5a3);
      wr(8'h00, 32'h0);
      sc_mode <= 1'b1;
      conv(12'h9c5);
      chk(captured, 12'h9c6);
      stop_test();
   end
endmodule // sar_conversion_sequencer_test
bind sar_conversion_sequencer sar_seq_sva u_sva (.clk(clk), .rstn(rstn),
   .pins(pins), .outs(outs), .irq(irq));
